// File: ewsp_host.sv
// Purpose : Host controller for a parallel EEPROM with software write lock
// Assumes : Device pins at the top, 200 MHz clock, synchronous reset
// Notes   : Lock and unlock command words are parameters
`include "ewsp_cfg.svh"
`timescale 1ns/1ps
// Operation
// - With the lock on, each write needs the three-command lock sequence first.
// - Lock enable is three command writes of fixed address and data.
// - Command writes and following writes use byte-load page timing.
// - Data writes after the sequence start inside the byte-load window.
// - With lock on, every write is preceded by the three commands.
// - Six command writes clear the lock.
module ewsp_host
  import ewsp_pkg::*;
#(
  parameter int              AW        = 15,
  parameter int unsigned     INIT_CYC  = `EWSP_INIT_CYC,
  parameter int unsigned     WC_CYC    = `EWSP_WC_CYC,
  parameter logic [6*AW-1:0] CMD_ADDR  = {6{AW'(0)}},
  parameter logic [47:0]     CMD_DATA  = 48'h0000_0000_0000
) (
  input  wire logic          ref_clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic          req_valid_in,
  input  wire ewsp_op_t      req_op_in,
  input  wire logic [AW-1:0] req_addr_in,
  input  wire logic [7:0]    req_data_in,
  input  wire logic          lock_on_in,
  input  wire logic          supply_ok_in,
  input  wire logic [7:0]    dq_in,
  output logic               req_ready_out,
  output logic               resp_valid_out,
  output logic [7:0]         resp_data_out,
  output logic               resp_timeout_out,
  output logic               lock_state_out,
  output logic               ce_n_out,
  output logic               oe_n_out,
  output logic               we_n_out,
  output logic               dq_oe_out,
  output logic [AW-1:0]      addr_out,
  output logic [7:0]         dq_out
);
  if (AW < 8 || AW > 24) begin : g_aw_chk
    $error("AW out of range");
  end
  if (INIT_CYC < 1 || WC_CYC < 1) begin : g_cnt_chk
    $error("Counts must be positive");
  end

  typedef enum {S_POR, S_IDLE, S_CMD, S_DATA, S_POLL, S_RESP} ewsp_st_t;
  ewsp_st_t                st_q;
  ewsp_op_t                op_q;
  logic [AW-1:0]           addr_q;
  logic [7:0]              data_q;
  logic [2:0]              idx_q;
  logic [2:0]              ncmd_q;
  logic [2:0]              base_q;
  logic                    busy_q;
  logic                    have_prev_q;
  logic [7:0]              prev_q;
  logic [`EWSP_CNT_W-1:0]  tmr_q;
  logic [1:0]              sup_sync_q;
  logic [7:0]              dq_s1_q;
  logic [7:0]              dq_s2_q;

  ewsp_strobe_if #(.AW(AW)) sif ();

  ewsp_strobe #(.AW(AW)) u_strobe (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .bus        (sif),
    .dq_sync_in (dq_s2_q),
    .ce_n_out   (ce_n_out),
    .oe_n_out   (oe_n_out),
    .we_n_out   (we_n_out),
    .dq_oe_out  (dq_oe_out),
    .addr_out   (addr_out),
    .dq_out     (dq_out)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sup_sync_q <= '0;
      dq_s1_q    <= '0;
      dq_s2_q    <= '0;
    end else begin
      sup_sync_q <= {sup_sync_q[0], supply_ok_in};
      dq_s1_q    <= dq_in;
      dq_s2_q    <= dq_s1_q;
    end
  end

  logic sup_ok;
  assign sup_ok = sup_sync_q[1];

  // ----------------------------------------------------------------
  // Strobe request
  // ----------------------------------------------------------------
  logic          cyc_go;
  logic          cyc_wr;
  logic [AW-1:0] cyc_addr;
  logic [7:0]    cyc_data;

  always_comb begin
    cyc_go   = 1'b0;
    cyc_wr   = 1'b1;
    cyc_addr = addr_q;
    cyc_data = data_q;
    unique case (st_q)
      S_CMD: begin
        cyc_go   = !busy_q;
        cyc_addr = CMD_ADDR[(base_q + idx_q) * AW +: AW];
        cyc_data = CMD_DATA[(base_q + idx_q) * 8 +: 8];
      end
      S_DATA: cyc_go = !busy_q;
      S_POLL: begin
        cyc_go = !busy_q;
        cyc_wr = 1'b0;
      end
      default: cyc_go = 1'b0;
    endcase
  end

  assign sif.start = cyc_go;
  assign sif.is_wr = cyc_wr;
  assign sif.addr  = cyc_addr;
  assign sif.wdata = cyc_data;

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_q             <= S_POR;
      op_q             <= EWSP_OP_READ;
      addr_q           <= '0;
      data_q           <= '0;
      idx_q            <= '0;
      ncmd_q           <= '0;
      base_q           <= '0;
      busy_q           <= 1'b0;
      have_prev_q      <= 1'b0;
      prev_q           <= '0;
      tmr_q            <= '0;
      req_ready_out    <= 1'b0;
      resp_valid_out   <= 1'b0;
      resp_data_out    <= '0;
      resp_timeout_out <= 1'b0;
      lock_state_out   <= 1'b0;
    end else begin
      resp_valid_out <= 1'b0;
      if (cyc_go) begin
        busy_q <= 1'b1;
      end else if (sif.done) begin
        busy_q <= 1'b0;
      end
      unique case (st_q)
        S_POR: begin
          if (!sup_ok) begin
            tmr_q <= '0;
          end else if (tmr_q >= `EWSP_CNT_W'(INIT_CYC)) begin
            st_q          <= S_IDLE;
            req_ready_out <= 1'b1;
          end else begin
            tmr_q <= tmr_q + `EWSP_CNT_W'(1);
          end
        end
        S_IDLE: begin
          if (!sup_ok) begin
            st_q          <= S_POR;
            tmr_q         <= '0;
            req_ready_out <= 1'b0;
          end else if (req_valid_in) begin
            req_ready_out    <= 1'b0;
            resp_timeout_out <= 1'b0;
            op_q   <= req_op_in;
            addr_q <= req_addr_in;
            data_q <= req_data_in;
            idx_q  <= '0;
            have_prev_q <= 1'b0;
            tmr_q  <= '0;
            unique case (req_op_in)
              EWSP_OP_READ: st_q <= S_POLL;
              EWSP_OP_POLL: st_q <= S_POLL;
              EWSP_OP_LOCK: begin
                base_q <= 3'd0;
                ncmd_q <= 3'd3;
                st_q   <= S_CMD;
              end
              EWSP_OP_UNLOCK: begin
                base_q <= 3'd0;
                ncmd_q <= 3'd6;
                st_q   <= S_CMD;
              end
              EWSP_OP_WRITE: begin
                base_q <= 3'd0;
                ncmd_q <= 3'd3;
                st_q   <= lock_on_in ? S_CMD : S_DATA;
              end
              // Unknown op code answers at once
              default: st_q <= S_RESP;
            endcase
          end
        end
        S_CMD: begin
          if (sif.done) begin
            if (idx_q == ncmd_q - 3'd1) begin
              idx_q <= '0;
              if (op_q == EWSP_OP_LOCK) begin
                lock_state_out <= 1'b1;
                st_q           <= S_POLL;
              end else if (op_q == EWSP_OP_UNLOCK) begin
                lock_state_out <= 1'b0;
                st_q           <= S_POLL;
              end else begin
                st_q <= S_DATA;
              end
            end else begin
              idx_q <= idx_q + 3'd1;
            end
          end
        end
        S_DATA: begin
          if (sif.done) begin
            st_q <= S_POLL;
          end
        end
        S_POLL: begin
          tmr_q <= tmr_q + `EWSP_CNT_W'(1);
          if (sif.done) begin
            have_prev_q <= 1'b1;
            prev_q      <= sif.rdata;
            if (op_q == EWSP_OP_READ) begin
              resp_data_out <= sif.rdata;
              st_q          <= S_RESP;
            end else if (have_prev_q &&
                         prev_q[`EWSP_TOGGLE_BIT] == sif.rdata[`EWSP_TOGGLE_BIT] &&
                         // Polling bit must match the written data bit after a write
                         (op_q != EWSP_OP_WRITE ||
                          sif.rdata[`EWSP_POLL_BIT] == data_q[`EWSP_POLL_BIT])) begin
              // Two reads with the same toggle bit end the wait
              resp_data_out <= sif.rdata;
              st_q          <= S_RESP;
            end else if (tmr_q >= `EWSP_CNT_W'(WC_CYC) + `EWSP_CNT_W'(`EWSP_BLC_MAX_CYC)) begin
              resp_timeout_out <= 1'b1;
              resp_data_out    <= sif.rdata;
              st_q             <= S_RESP;
            end
          end
        end
        S_RESP: begin
          resp_valid_out <= 1'b1;
          req_ready_out  <= 1'b1;
          st_q           <= S_IDLE;
        end
      endcase
    end
  end
endmodule // ewsp_host

// File: ewsp_cfg.svh
// Purpose : Timing and status-bit constants for the parallel EEPROM host controller
// Assumes : 200 MHz ref_clk_in (5 ns period)
// Notes   : Counts derive from times in their own unit
`ifndef EWSP_CFG_SVH
`define EWSP_CFG_SVH

`define EWSP_CLK_PS          5000
// Strobe pulse width, least, ns
`define EWSP_T_WP_NS         100
`define EWSP_WP_CYC          ((`EWSP_T_WP_NS * 1000 + `EWSP_CLK_PS - 1) / `EWSP_CLK_PS)
// Strobe high time between byte loads, ns
`define EWSP_BYTE_LOAD_WINDOW_MIN_NS    100
`define EWSP_BLC_MIN_CYC     ((`EWSP_BYTE_LOAD_WINDOW_MIN_NS * 1000 + `EWSP_CLK_PS - 1) / `EWSP_CLK_PS)
// Byte load window, longest, us
`define EWSP_BYTE_LOAD_WINDOW_MAX_US    100
`define EWSP_BLC_MAX_CYC     ((`EWSP_BYTE_LOAD_WINDOW_MAX_US * 1000000) / `EWSP_CLK_PS)
// Read access, least, ns
`define EWSP_T_RD_NS         150
`define EWSP_RD_CYC          ((`EWSP_T_RD_NS * 1000 + `EWSP_CLK_PS - 1) / `EWSP_CLK_PS)
// Power-on write inhibit, longest, ms
`define EWSP_T_INIT_MS       10
`define EWSP_INIT_CYC        ((`EWSP_T_INIT_MS * 1000000) / (`EWSP_CLK_PS / 1000))
// Self-timed write, longest, ms
`define EWSP_T_WC_MS         5
`define EWSP_WC_CYC          ((`EWSP_T_WC_MS * 1000000) / (`EWSP_CLK_PS / 1000))
`define EWSP_TOGGLE_BIT      6
`define EWSP_POLL_BIT        7
`define EWSP_CNT_W           32

`endif

// File: ewsp_pkg.sv
// Purpose : Types shared by the EEPROM host controller
// Assumes : Nothing
// Notes   : A request can run several bus cycles: command writes, a data write and polling reads
package ewsp_pkg;
  typedef enum logic [2:0] {
    EWSP_OP_READ,
    EWSP_OP_WRITE,
    EWSP_OP_LOCK,
    EWSP_OP_UNLOCK,
    EWSP_OP_POLL
  } ewsp_op_t;
endpackage

// File: ewsp_strobe_if.sv
// Purpose : Carries one bus cycle between sequencer and strobe engine
// Assumes : Single clock domain
// Notes   : start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
interface ewsp_strobe_if #(parameter int AW = 15) ();
  logic          start;
  logic          is_wr;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic          done;
  logic [7:0]    rdata;
  modport seq (output start, output is_wr, output addr, output wdata,
               input done, input rdata);
  modport eng (input start, input is_wr, input addr, input wdata,
               output done, output rdata);
endinterface

// File: ewsp_strobe.sv
// Purpose : Drives one read or write cycle on the EEPROM pins
// Assumes : Pins are registered in this module and passed straight through the top
// Notes   : Write pulse is far above the noise-reject width
`include "ewsp_cfg.svh"
`timescale 1ns/1ps
module ewsp_strobe
  import ewsp_pkg::*;
#(
  parameter int AW = 15
) (
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  ewsp_strobe_if.eng      bus,
  input  wire logic [7:0] dq_sync_in,
  output logic            ce_n_out,
  output logic            oe_n_out,
  output logic            we_n_out,
  output logic            dq_oe_out,
  output logic [AW-1:0]   addr_out,
  output logic [7:0]      dq_out
);
  typedef enum {ST_IDLE, ST_PULSE, ST_GAP} ewsp_eng_t;
  ewsp_eng_t             st_q;
  logic [`EWSP_CNT_W-1:0] cnt_q;
  logic                  wr_q;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_q      <= ST_IDLE;
      cnt_q     <= '0;
      wr_q      <= 1'b0;
      ce_n_out  <= 1'b1;
      oe_n_out  <= 1'b1;
      we_n_out  <= 1'b1;
      dq_oe_out <= 1'b0;
      addr_out  <= '0;
      dq_out    <= '0;
      bus.done  <= 1'b0;
      bus.rdata <= '0;
    end else begin
      bus.done <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (bus.start) begin
            wr_q     <= bus.is_wr;
            addr_out <= bus.addr;
            dq_out   <= bus.wdata;
            ce_n_out <= 1'b0;
            oe_n_out  <= bus.is_wr;
            we_n_out  <= !bus.is_wr;
            dq_oe_out <= bus.is_wr;
            cnt_q <= bus.is_wr ? `EWSP_CNT_W'(`EWSP_WP_CYC) : `EWSP_CNT_W'(`EWSP_RD_CYC);
            st_q  <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (cnt_q > `EWSP_CNT_W'(1)) begin
            cnt_q <= cnt_q - `EWSP_CNT_W'(1);
          end else begin
            if (!wr_q) begin
              bus.rdata <= dq_sync_in;
            end
            ce_n_out  <= 1'b1;
            oe_n_out  <= 1'b1;
            we_n_out  <= 1'b1;
            dq_oe_out <= 1'b0;
            cnt_q     <= `EWSP_CNT_W'(`EWSP_BLC_MIN_CYC);
            st_q      <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (cnt_q > `EWSP_CNT_W'(1)) begin
            cnt_q <= cnt_q - `EWSP_CNT_W'(1);
          end else begin
            bus.done <= 1'b1;
            st_q     <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule // ewsp_strobe

// File: ewsp_host_props.sv
// Purpose : Port checks for the EEPROM host controller
// Assumes : Single clock, synchronous active-high reset
// Notes   : Bound to ewsp_host from the testbench top
`timescale 1ns/1ps
module ewsp_host_props #(
  parameter int unsigned INIT_CYC = 50
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire logic supply_ok_in,
  input wire logic req_ready_out,
  input wire logic resp_valid_out,
  input wire logic lock_state_out,
  input wire logic ce_n_out,
  input wire logic oe_n_out,
  input wire logic we_n_out,
  input wire logic dq_oe_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  int unsigned since_q;
  // Cycles since reset or supply loss
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !supply_ok_in) since_q <= 0;
    else if (since_q <= INIT_CYC) since_q <= since_q + 1;
  end
  property p_rst;
    disable iff (1'b0) sys_rst_in |=> ce_n_out && oe_n_out && we_n_out && !dq_oe_out
      && !req_ready_out;
  endproperty
  a_rst: assert property (p_rst) else $error("strobes not idle in reset");
  property p_init; $rose(req_ready_out) |-> since_q >= INIT_CYC; endproperty
  a_init: assert property (p_init) else $error("ready before inhibit");
  property p_sup; !supply_ok_in [*5] |-> !req_ready_out; endproperty
  a_sup: assert property (p_sup) else $error("ready with supply low");
  property p_we; !we_n_out |-> !ce_n_out && oe_n_out; endproperty
  a_we: assert property (p_we) else $error("write strobe without enables");
  property p_dq; dq_oe_out |-> oe_n_out && !ce_n_out; endproperty
  a_dq: assert property (p_dq) else $error("data driven outside write");
  property p_rd; !oe_n_out |-> we_n_out && !dq_oe_out; endproperty
  a_rd: assert property (p_rd) else $error("read overlaps write");
  property p_wp; $fell(we_n_out) |-> !we_n_out [*8]; endproperty
  a_wp: assert property (p_wp) else $error("write pulse too short");
  property p_acc; req_valid_in && req_ready_out |=> !req_ready_out; endproperty
  a_acc: assert property (p_acc) else $error("ready stays after accept");
  property p_resp; resp_valid_out |=> !resp_valid_out; endproperty
  a_resp: assert property (p_resp) else $error("response longer than a cycle");
  c_wr: cover property ($fell(we_n_out));
  c_lock: cover property ($rose(lock_state_out));
  c_unlock: cover property ($fell(lock_state_out));
endmodule // ewsp_host_props

// File: ewsp_dev_model.sv
// Purpose : Behavioural parallel EEPROM with write lock and status bits
// Assumes : Strobes come from a registered host
// Notes   : Programming starts at the strobe rise, 16 bytes stored
`timescale 1ns/1ps
module ewsp_dev_model #(
  parameter int              AW      = 15,
  parameter int              BUSY    = 120,
  parameter real             INIT_NS = 200.0,
  parameter logic [6*AW-1:0] CA      = '0,
  parameter logic [47:0]     CD      = '0
) (
  input  wire logic          clk_in,
  input  wire logic          sup_ok_in,
  input  wire logic          ce_n_in,
  input  wire logic          oe_n_in,
  input  wire logic          we_n_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [7:0]    din_in,
  output logic [7:0]         dout_out,
  output logic               lock_out,
  output logic               busy_out
);
  logic [7:0]    mem [16];
  logic [7:0]    last_d, rd, hold_q, d_q;
  logic [AW-1:0] a_q;
  logic          tog_q, we_q, ce_q, oe_q;
  real           t_end, t_ok, t_fall;
  int            seq;
  // lock off at start, cells blank
  initial begin
    lock_out = 1'b0; busy_out = 1'b0; tog_q = 1'b0; hold_q = 8'h00;
    seq = 0; t_end = 0.0; t_ok = 0.0; t_fall = 0.0; last_d = 8'h00;
    we_q = 1'b1;
    ce_q = 1'b1;
    oe_q = 1'b1;
    a_q = '0;
    d_q = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge sup_ok_in) t_ok = $realtime + INIT_NS;
  always @(negedge we_n_in) t_fall = $realtime;
  // Pins are seen before the host's edge updates, so a strobe rise shows one edge later
  always @(posedge clk_in) begin
    if (we_n_in && !we_q && !ce_q && oe_q && sup_ok_in && $realtime >= t_ok &&
        $realtime - 5.0 - t_fall >= 20.0) begin
      // command count, a first command restarts it
      if (seq < 6 && a_q == CA[seq*AW+:AW] && d_q == CD[seq*8+:8]) seq = seq + 1;
      else if (a_q == CA[AW-1:0] && d_q == CD[7:0]) seq = 1;
      else if (!lock_out || seq == 3) begin
        mem[a_q[3:0]] = d_q;
        last_d = d_q;
        t_end = $realtime + BUSY * 5.0;
        seq = 0;
      end else seq = 0;
      if (seq == 3) lock_out = 1'b1;
      if (seq == 6) begin
        lock_out = 1'b0;
        seq = 0;
      end
    end
    we_q = we_n_in;
    ce_q = ce_n_in;
    oe_q = oe_n_in;
    a_q = addr_in;
    d_q = din_in;
    busy_out <= $realtime < t_end;
    hold_q <= dout_out;
  end
  always @(posedge oe_n_in) if (busy_out) tog_q = ~tog_q;
  assign rd = busy_out ? {~last_d[7], tog_q, last_d[5:0]} : mem[addr_in[3:0]];
  assign dout_out = (!ce_n_in && !oe_n_in) ? rd : ~hold_q;
endmodule // ewsp_dev_model

// File: ewsp_host_tb_top.sv
// Purpose : Self-checking bench for the EEPROM host controller
// Assumes : Inputs change 1 ns after the rising edge
// Notes   : Short inhibit and write counts for simulation
`timescale 1ns/1ps
module ewsp_host_tb_top;
  import ewsp_pkg::*;
  localparam int              AW = 15;
  localparam logic [6*AW-1:0] CA = {15'h1555, 15'h2aaa, 15'h1555, 15'h1555, 15'h2aaa, 15'h1555};
  localparam logic [47:0]     CD = 48'h20aa_80a0_55aa;
  logic          clk, rst, valid, lock_on, sup_ok, ready, rvalid, tmo, lock_st;
  logic          ce_n, oe_n, we_n, dq_oe, dlock, dbusy;
  ewsp_op_t      op;
  logic [AW-1:0] addr, addr_o;
  logic [7:0]    data, dq_i, dq_o, rdata;
  int            num_errors, cmp_count;
  ewsp_host #(.AW(AW), .INIT_CYC(50), .WC_CYC(200), .CMD_ADDR(CA), .CMD_DATA(CD)) u_dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .req_valid_in(valid), .req_op_in(op),
    .req_addr_in(addr), .req_data_in(data), .lock_on_in(lock_on), .supply_ok_in(sup_ok),
    .dq_in(dq_i), .req_ready_out(ready), .resp_valid_out(rvalid), .resp_data_out(rdata),
    .resp_timeout_out(tmo), .lock_state_out(lock_st), .ce_n_out(ce_n), .oe_n_out(oe_n),
    .we_n_out(we_n), .dq_oe_out(dq_oe), .addr_out(addr_o), .dq_out(dq_o));
  ewsp_dev_model #(.AW(AW), .CA(CA), .CD(CD)) u_dev (
    .clk_in(clk), .sup_ok_in(sup_ok), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .addr_in(addr_o), .din_in(dq_oe ? dq_o : ~dq_o), .dout_out(dq_i), .lock_out(dlock),
    .busy_out(dbusy));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic wait_hi(input bit want_resp);
    int n;
    n = 0;
    while ((want_resp ? rvalid : ready) !== 1'b1) begin
      @(posedge clk); #1;
      n++;
      if (n > 30000) begin
        num_errors++;
        complete_run();
      end
    end
  endtask
  task automatic do_op(input ewsp_op_t o, input logic [AW-1:0] a, input logic [7:0] d);
    wait_hi(1'b0);
    valid = 1'b1; op = o; addr = a; data = d;
    @(posedge clk); #1;
    valid = 1'b0;
    wait_hi(1'b1);
    chk("timeout", 8'h00, 8'(tmo));
  endtask
  task automatic t_plain();
    chk("lock at start", 8'h00, 8'(dlock));
    do_op(EWSP_OP_WRITE, 15'h0003, 8'h5a);
    chk("busy at done", 8'h00, 8'(dbusy));
    do_op(EWSP_OP_READ, 15'h0003, 8'h00);
    chk("read back", 8'h5a, rdata);
    do_op(EWSP_OP_WRITE, 15'h0009, 8'hc3);
    do_op(EWSP_OP_POLL, 15'h0009, 8'h00);
    chk("poll result", 8'hc3, rdata);
    $display("test plain done");
  endtask
  task automatic t_lock();
    do_op(EWSP_OP_LOCK, 15'h0000, 8'h00);
    chk("host lock", 8'h01, 8'(lock_st));
    chk("device lock", 8'h01, 8'(dlock));
    lock_on = 1'b1;
    do_op(EWSP_OP_WRITE, 15'h0003, 8'h96);
    do_op(EWSP_OP_READ, 15'h0003, 8'h00);
    chk("locked write", 8'h96, rdata);
    chk("still locked", 8'h01, 8'(dlock));
    $display("test lock done");
  endtask
  task automatic t_unlock();
    do_op(EWSP_OP_UNLOCK, 15'h0000, 8'h00);
    chk("host unlock", 8'h00, 8'(lock_st));
    chk("device unlock", 8'h00, 8'(dlock));
    lock_on = 1'b0;
    do_op(EWSP_OP_WRITE, 15'h0009, 8'h3c);
    do_op(EWSP_OP_READ, 15'h0009, 8'h00);
    chk("plain after unlock", 8'h3c, rdata);
    $display("test unlock done");
  endtask
  task automatic t_supply();
    sup_ok = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("ready in low supply", 8'h00, 8'(ready));
    sup_ok = 1'b1;
    do_op(EWSP_OP_WRITE, 15'h0003, 8'h11);
    do_op(EWSP_OP_READ, 15'h0003, 8'h00);
    chk("write after power up", 8'h11, rdata);
    $display("test supply done");
  endtask
  initial begin
    num_errors = 0; cmp_count = 0;
    rst = 1'b1; valid = 1'b0; op = EWSP_OP_READ; addr = 15'h0000; data = 8'h00;
    lock_on = 1'b0; sup_ok = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_plain();
    t_lock();
    t_unlock();
    t_supply();
    complete_run();
  end
endmodule // ewsp_host_tb_top
bind ewsp_host ewsp_host_props #(.INIT_CYC(INIT_CYC)) u_props (
  .ref_clk_in     (ref_clk_in),
  .sys_rst_in     (sys_rst_in),
  .req_valid_in   (req_valid_in),
  .supply_ok_in   (supply_ok_in),
  .req_ready_out  (req_ready_out),
  .resp_valid_out (resp_valid_out),
  .lock_state_out (lock_state_out),
  .ce_n_out       (ce_n_out),
  .oe_n_out       (oe_n_out),
  .we_n_out       (we_n_out),
  .dq_oe_out      (dq_oe_out)
);
